// file: rtl/wdt_pkg.sv
// Shared constants, types and helpers of the windowed watchdog
package wdt_pkg;

    // Timing of the core clock and of the low-power RC oscillator
    localparam int CLK_HZ          = 250_000_000; // Core clock rate
    localparam int RC_OSC_HZ       = 32_000;      // Nominal oscillator rate
    localparam int RC_DIV_CYCLES   = CLK_HZ / RC_OSC_HZ; // Core cycles a tick

    // Base time-out periods of the two prescaler settings
    localparam int BASE_SHORT_US   = 1000;        // 5-bit prescaler, 1 ms
    localparam int BASE_LONG_US    = 4000;        // 7-bit prescaler, 4 ms
    localparam int PRE_SHORT_TICKS = BASE_SHORT_US * RC_OSC_HZ / 1_000_000;
    localparam int PRE_LONG_TICKS  = BASE_LONG_US * RC_OSC_HZ / 1_000_000;

    // Elapsed counter covers 128 x 32768 oscillator ticks
    localparam int CNT_W  = 23;                   // Counter width
    localparam int ADDR_W = 8;                    // Register address width
    localparam int DATA_W = 32;                   // Register data width

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 8'h00; // Status/enable
    localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 8'h04; // Config word
    localparam logic [ADDR_W-1:0] ADDR_ELAPSED    = 8'h08; // Live count

    // Reset control register fields
    localparam int BIT_IDLE    = 2;               // Woke from Idle
    localparam int BIT_SLEEP   = 3;               // Woke from Sleep
    localparam int BIT_TIMEOUT = 4;               // Time-out happened
    localparam int BIT_SOFT_EN = 5;               // Software enable

    // Configuration word fields
    localparam int CFG_POST_LSB  = 0;             // Postscaler, 4 bits
    localparam int CFG_PRE_BIT   = 4;             // 1 = 7-bit prescaler
    localparam int CFG_WIN_OFF   = 6;             // 1 = window disabled
    localparam int CFG_EN_BIT    = 7;             // 1 = always enabled
    localparam logic [7:0] CFG_RESET = 8'h40;     // Window off, soft mode

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;    // Access done
    localparam logic [1:0] RESP_SLVERR = 2'h2;    // Unmapped address

    // Power-save state, Gray coded
    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_SAVE = 2'h1
    } pwr_state_t;

    // Oscillator ticks in one full time-out period
    function automatic logic [CNT_W-1:0] periodTicks(
        input logic       preLong,
        input logic [3:0] post
    );
        logic [CNT_W-1:0] base;
        base = preLong ? CNT_W'(PRE_LONG_TICKS) : CNT_W'(PRE_SHORT_TICKS);
        return base << post;
    endfunction

    // True for an offset that holds a register
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_RESET_CTRL) || (addr == ADDR_CONFIG) ||
               (addr == ADDR_ELAPSED);
    endfunction

endpackage

// file: rtl/reg_bus_if.sv
// Internal register strobe bus between bus slave and watchdog core
`timescale 1ns/10ps
interface reg_bus_if;
    import wdt_pkg::*;
    logic              wrEn;   // One-cycle write strobe
    logic [ADDR_W-1:0] wrAddr; // Write offset
    logic [DATA_W-1:0] wrData; // Write data
    logic [3:0]        wrStrb; // Byte enables
    logic [ADDR_W-1:0] rdAddr; // Read offset
    logic [DATA_W-1:0] rdData; // Read data, combinational

    // Bus side drives strobes and addresses
    modport bus  (output wrEn, wrAddr, wrData, wrStrb, rdAddr,
                  input  rdData);
    // Register side answers reads
    modport regs (input  wrEn, wrAddr, wrData, wrStrb, rdAddr,
                  output rdData);
endinterface

// file: rtl/axil_reg_slave.sv
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/10ps
module axil_reg_slave
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // Write address and data
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // Write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // Read address and data
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [DATA_W-1:0]        rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // Register side
    reg_bus_if.bus                   rb
);
    logic              awHeld_reg;   // Address captured
    logic              wHeld_reg;    // Data captured
    logic [ADDR_W-1:0] awAddr_reg;   // Captured address
    logic [DATA_W-1:0] wData_reg;    // Captured data
    logic [3:0]        wStrb_reg;    // Captured enables
    logic              doWrite;      // Both halves present

    // Either half may come first; nothing new while a response waits
    assign awready   = !awHeld_reg && !bvalid;
    assign wready    = !wHeld_reg && !bvalid;
    assign doWrite   = awHeld_reg && wHeld_reg && !bvalid;
    assign arready   = !rvalid;
    assign rb.wrEn   = doWrite;
    assign rb.wrAddr = awAddr_reg;
    assign rb.wrData = wData_reg;
    assign rb.wrStrb = wStrb_reg;
    assign rb.rdAddr = araddr;

    // Write path
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            awAddr_reg <= '0;
            wData_reg  <= '0;
            wStrb_reg  <= '0;
            bvalid     <= 1'b0;
            bresp      <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg  <= 1'b0;
                bvalid     <= 1'b1;
                bresp      <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read path, data sampled at the address handshake
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rb.rdData;
            rresp  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// file: rtl/windowed_watchdog_timer.sv
// Windowed watchdog core with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module windowed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int RC_DIV = RC_DIV_CYCLES      // Core cycles per RC tick
)(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [DATA_W-1:0]        rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // Processor events, one-cycle pulses, and the powerSaveIdle level
    input  wire logic                wdClearInstr,
    input  wire logic                powerSaveInstr,
    input  wire logic                powerSaveIdle,
    input  wire logic                wakeRequest,
    input  wire logic                clockSwitchDone,
    // Outputs to clock and reset logic
    output logic                     lpRcEnable,
    output logic                     wdResetReq,
    output logic                     wakeUp,
    output logic                     powerSaved
);
    import wdt_pkg::*;

    localparam int DIV_W = $clog2(RC_DIV);    // Divider width

    // Divider needs at least two cycles to give a one-cycle tick
    if (RC_DIV < 2) begin : g_div_check
        $error("RC_DIV must be at least 2");
    end

    reg_bus_if rb ();                          // Internal register bus

    // Register state
    logic [7:0]       config_reg;              // Configuration word
    logic             softEn_reg;              // Software enable
    logic             timeoutFlag_reg;         // Sticky time-out
    logic             sleepFlag_reg;           // Sticky Sleep flag
    logic             idleFlag_reg;            // Sticky Idle flag
    pwr_state_t       state_reg;               // Run or power save
    pwr_state_t       state_next;
    logic [DIV_W-1:0] divCnt_reg;              // Oscillator model
    logic [CNT_W-1:0] elapsed_reg;             // Ticks since last clear
    logic [CNT_W-1:0] elapsed_next;
    logic             lpRcEn_reg;              // Oscillator enable
    logic             wdReset_reg;             // Reset request pulse
    logic             wake_reg;                // Wake pulse

    // Decoded configuration
    logic             cfgEnable;               // Always-on mode
    logic             windowDisable;           // No clear window
    logic             preLong;                 // 7-bit prescaler
    logic [3:0]       postSel;                 // Postscaler setting
    logic             wdEnabled;               // Watchdog running

    // Timing terms
    logic             rcTick;                  // One oscillator period
    logic [CNT_W-1:0] termTicks;               // Full period in ticks
    logic [CNT_W-1:0] windowStart;             // Start of last quarter
    logic             windowOpen;              // Clear is allowed
    logic             timeoutHit;              // Period ends this tick

    // Events
    logic             inRun;                   // Normal execution
    logic             enterSave;               // Power save begins
    logic             exitSave;                // Power save ends
    logic             clearEarly;              // Clear before window
    logic             runTimeout;              // Time-out while running
    logic             saveTimeout;             // Time-out while saved
    logic             wdResetEvt;              // Reset requested now
    logic             counterClear;            // Restart counting

    // Register writes
    logic             wrResetCtrl;             // Write to status/enable
    logic             wrConfig;                // Write to config word
    logic             wrSoftBit;               // Written enable value
    logic             swClearTimeout;          // Software clears flag
    logic             swClearSleep;
    logic             swClearIdle;

    // Bus slave
    axil_reg_slave u_slave (
        .clock   (clock),
        .resetn  (resetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rb      (rb.bus)
    );

    // Configuration fields
    assign cfgEnable     = config_reg[CFG_EN_BIT];
    assign windowDisable = config_reg[CFG_WIN_OFF];
    assign preLong       = config_reg[CFG_PRE_BIT];
    assign postSel       = config_reg[CFG_POST_LSB +: 4];
    assign wdEnabled     = cfgEnable || softEn_reg;

    // Ticks only while the oscillator runs
    assign rcTick      = lpRcEn_reg &&
                         (divCnt_reg == DIV_W'(RC_DIV - 1));
    assign termTicks   = periodTicks(preLong, postSel);
    assign windowStart = termTicks - (termTicks >> 2);
    assign windowOpen  = elapsed_reg >= windowStart;
    assign timeoutHit  = wdEnabled && rcTick &&
                         (elapsed_reg == termTicks - 1'b1);

    // Event decoding; a clear in the same cycle rescues a time-out
    assign inRun       = (state_reg == ST_RUN);
    assign enterSave   = inRun && powerSaveInstr;
    assign exitSave    = !inRun && (wakeRequest || timeoutHit);
    assign clearEarly  = inRun && wdClearInstr && wdEnabled &&
                         !windowDisable && !windowOpen;
    assign runTimeout  = inRun && timeoutHit && !wdClearInstr &&
                         !powerSaveInstr && !clockSwitchDone;
    assign saveTimeout = !inRun && timeoutHit && !clockSwitchDone;
    assign wdResetEvt  = runTimeout || clearEarly;
    assign counterClear = clockSwitchDone || enterSave || exitSave ||
                          (inRun && wdClearInstr) || wdResetEvt ||
                          !wdEnabled;

    // Register write decode, fields sit in the low byte
    assign wrResetCtrl = rb.wrEn && rb.wrStrb[0] &&
                         (rb.wrAddr == ADDR_RESET_CTRL);
    assign wrConfig    = rb.wrEn && rb.wrStrb[0] &&
                         (rb.wrAddr == ADDR_CONFIG);
    assign wrSoftBit   = rb.wrData[BIT_SOFT_EN];
    assign swClearTimeout = wrResetCtrl && !rb.wrData[BIT_TIMEOUT];
    assign swClearSleep   = wrResetCtrl && !rb.wrData[BIT_SLEEP];
    assign swClearIdle    = wrResetCtrl && !rb.wrData[BIT_IDLE];

    // Read mux; unmapped offsets read zero
    assign rb.rdData =
        (rb.rdAddr == ADDR_RESET_CTRL) ?
            {26'h0, softEn_reg, timeoutFlag_reg, sleepFlag_reg,
             idleFlag_reg, 2'h0} :
        (rb.rdAddr == ADDR_CONFIG)  ? {24'h0, config_reg} :
        (rb.rdAddr == ADDR_ELAPSED) ? {{(DATA_W-CNT_W){1'b0}}, elapsed_reg} :
        32'h0;

    // Counter restarts on any clearing event, else counts ticks
    assign elapsed_next = counterClear ? '0 :
                          rcTick ? CNT_W'(elapsed_reg + 1'b1) :
                          elapsed_reg;

    // Power state: save on the instruction, leave on wake or time-out
    always_comb begin
        case (state_reg)
            ST_RUN:  state_next = enterSave ? ST_SAVE : ST_RUN;
            ST_SAVE: state_next = exitSave ? ST_RUN : ST_SAVE;
            default: state_next = ST_RUN;
        endcase
    end

    // Outputs
    assign lpRcEnable = lpRcEn_reg;
    assign wdResetReq = wdReset_reg;
    assign wakeUp     = wake_reg;
    assign powerSaved = (state_reg == ST_SAVE);

    // Oscillator divider; held at zero while stopped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            divCnt_reg <= '0;
        end else if (!lpRcEn_reg || rcTick) begin
            divCnt_reg <= '0;
        end else begin
            divCnt_reg <= DIV_W'(divCnt_reg + 1'b1);
        end
    end

    // Counter, state and event pulses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            elapsed_reg <= '0;
            state_reg   <= ST_RUN;
            lpRcEn_reg  <= 1'b0;
            wdReset_reg <= 1'b0;
            wake_reg    <= 1'b0;
        end else begin
            elapsed_reg <= elapsed_next;
            state_reg   <= state_next;
            lpRcEn_reg  <= wdEnabled;
            wdReset_reg <= wdResetEvt;
            wake_reg    <= saveTimeout;
        end
    end

    // Configuration word, written by software
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_reg <= CFG_RESET;
        end else if (wrConfig) begin
            config_reg <= rb.wrData[7:0];
        end
    end

    // Software enable; our own reset request clears it as well
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            softEn_reg <= 1'b0;
        end else if (wdResetEvt) begin
            softEn_reg <= 1'b0;
        end else if (wrResetCtrl) begin
            softEn_reg <= wrSoftBit;
        end
    end

    // Sticky flags: hardware set wins over a software clear.
    // They survive the reset request so software can see the cause.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timeoutFlag_reg <= 1'b0;
            sleepFlag_reg   <= 1'b0;
            idleFlag_reg    <= 1'b0;
        end else begin
            timeoutFlag_reg <= (runTimeout || saveTimeout || clearEarly) ||
                               (timeoutFlag_reg && !swClearTimeout);
            sleepFlag_reg   <= (enterSave && !powerSaveIdle) ||
                               (sleepFlag_reg && !swClearSleep);
            idleFlag_reg    <= (enterSave && powerSaveIdle) ||
                               (idleFlag_reg && !swClearIdle);
        end
    end

    // Checks on the watchdog behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_enter_save;
        inRun && powerSaveInstr;
    endsequence

    sequence s_saved_fresh;
        (state_reg == ST_SAVE) && (elapsed_reg == '0);
    endsequence

    sequence s_woken;
        wakeUp && !wdResetReq && (state_reg == ST_RUN) && timeoutFlag_reg;
    endsequence

    property p_osc_gates_tick;
        !lpRcEnable |-> !rcTick;
    endproperty
    a_osc_gates_tick: assert property (p_osc_gates_tick)
        else $error("tick without oscillator enable");

    property p_base_period;
        timeoutHit && (postSel == 4'h0) |->
            (elapsed_reg == (preLong ? 23'h7f : 23'h1f));
    endproperty
    a_base_period: assert property (p_base_period)
        else $error("base period not 32 or 128 ticks");

    property p_post_period;
        timeoutHit |-> (elapsed_reg == CNT_W'((preLong ? 128 : 32) *
                        (1 << postSel) - 1));
    endproperty
    a_post_period: assert property (p_post_period)
        else $error("postscaled period wrong");

    property p_switch_clears;
        clockSwitchDone |=> (elapsed_reg == '0) && !wakeUp;
    endproperty
    a_switch_clears: assert property (p_switch_clears)
        else $error("clock switch did not clear counter");

    property p_save_entry;
        s_enter_save |=> s_saved_fresh;
    endproperty
    a_save_entry: assert property (p_save_entry)
        else $error("power save entry did not clear counter");

    property p_clear_instr;
        inRun && wdClearInstr |=> (elapsed_reg == '0);
    endproperty
    a_clear_instr: assert property (p_clear_instr)
        else $error("clear instruction did not restart counter");

    property p_save_wake;
        saveTimeout |=> s_woken;
    endproperty
    a_save_wake: assert property (p_save_wake)
        else $error("time-out in power save did not wake");

    property p_sleep_sticky;
        sleepFlag_reg && !swClearSleep |=> sleepFlag_reg;
    endproperty
    a_sleep_sticky: assert property (p_sleep_sticky)
        else $error("sleep flag dropped without software");

    property p_always_on;
        cfgEnable && wrResetCtrl && !wrSoftBit |=> ##1 lpRcEnable;
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("software stopped an always-on watchdog");

    property p_soft_switch;
        !cfgEnable && !wrConfig && wrResetCtrl && !wdResetEvt |=>
            ##1 (lpRcEnable == $past(wrSoftBit, 2));
    endproperty
    a_soft_switch: assert property (p_soft_switch)
        else $error("software enable not followed");

    property p_early_clear;
        clearEarly |=> wdResetReq ##1 !wdResetReq;
    endproperty
    a_early_clear: assert property (p_early_clear)
        else $error("early clear did not request reset");

    property p_flag_sticky;
        timeoutFlag_reg && !swClearTimeout |=> timeoutFlag_reg;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("time-out flag dropped without software");

    property p_run_reset;
        runTimeout |=> wdResetReq && timeoutFlag_reg && !softEn_reg;
    endproperty
    a_run_reset: assert property (p_run_reset)
        else $error("running time-out did not request reset");
endmodule

// file: verification/windowed_watchdog_timer_test.sv
// Randomised self-checking bench of the windowed watchdog
`timescale 1ns/10ps
module windowed_watchdog_timer_test;
    import wdt_pkg::*;
    localparam int DIV = 4;       // Short RC tick keeps the run brief
    logic [7:0]  awaddr, araddr, cfg;
    logic [31:0] wdata, rdata, lfsr, rd;
    logic [3:0]  wstrb, ev;       // Byte enables; event pulses, one bit each
    logic [1:0]  bresp, rresp, rs;
    logic        clock, resetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, powerSaveIdle;
    logic        lpRcEnable, wdResetReq, wakeUp, powerSaved;
    wire         wdClearInstr, clockSwitchDone, powerSaveInstr, wakeRequest;
    int          err_total, tests_run, cyc, guard;
    assign {wakeRequest, powerSaveInstr, clockSwitchDone, wdClearInstr} = ev;
    windowed_watchdog_timer #(.RC_DIV(DIV)) DUT (.clock, .resetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .wdClearInstr, .powerSaveInstr,
        .powerSaveIdle, .wakeRequest, .clockSwitchDone, .lpRcEnable,
        .wdResetReq, .wakeUp, .powerSaved);
    // Core clock, 4 ns period
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Hang guard, well above the longest expected run
    always @(posedge clock) begin
        guard++;
        if (guard == 20000) begin
            err_total++;
            summarize();
        end
    end
    // Stimulus source, fixed seed
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Oscillator ticks in one time-out period
    function automatic int expTicks(input logic [7:0] c);
        return (c[4] ? 128 : 32) << c[3:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Write one word, response into rs; handshakes sampled when settled
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clock);
            ta = awready;
            tw = wready;
            tb = bvalid;
            rs = bresp;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    // Read one word into rd and its response into rs
    task automatic rdReg(input logic [7:0] a);
        logic ta, tr;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clock);
            ta = arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    // One-cycle pulse on event input number w
    task automatic evt(input int w);
        @(posedge clock);
        ev <= 4'(1 << w);
        @(posedge clock);
        ev <= 4'h0;
        @(negedge clock);
    endtask
    // Cycles until a reset request, or a wake pulse when up is set
    task automatic waitEv(input logic up);
        cyc = 0;
        // Look first: the pulse may already stand at this negedge
        while (!(up ? wakeUp : wdResetReq)) begin
            @(negedge clock);
            cyc++;
        end
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, powerSaveIdle} = 6'h0;
        {awaddr, araddr, wdata, wstrb, ev} = '0;
        {err_total, tests_run, guard} = '0;
        lfsr = 32'h754eb2a7;
        wstrb = 4'hf;
        resetn = 1'b0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rdReg(ADDR_RESET_CTRL);
        chk(rd, 32'h0);
        rdReg(8'h0c);
        chk(32'(rs), 32'(RESP_SLVERR));
        chk(rd, 32'h0);
        // Unmapped write must answer an error and change nothing
        wrReg(8'h0c, 32'h20);
        chk(32'(rs), 32'(RESP_SLVERR));
        rdReg(ADDR_RESET_CTRL);
        chk(rd, 32'h0);
        // Random prescaler and postscaler, window off
        for (int k = 0; k < 4; k++) begin
            lfsr = nextRand(lfsr);
            cfg = {3'h2, lfsr[4], 2'h0, lfsr[1:0] % 2'h3};
            wrReg(ADDR_CONFIG, 32'(cfg));
            chk(32'(rs), 32'(RESP_OKAY));
            wrReg(ADDR_RESET_CTRL, 32'h20);
            @(negedge clock);
            chk(32'(lpRcEnable), 32'h1);
            waitEv(1'b0);
            chk(32'((cyc + 9) / (DIV * expTicks(cfg))), 32'h1);
            rdReg(ADDR_RESET_CTRL);
            chk(rd, 32'h10);
            chk(32'(lpRcEnable), 32'h0);
            wrReg(ADDR_RESET_CTRL, 32'h0);
        end
        // Clear instruction, then clock switch, restart the count
        wrReg(ADDR_CONFIG, 32'h41);
        wrReg(ADDR_RESET_CTRL, 32'h20);
        for (int k = 0; k < 2; k++) begin
            repeat (100) @(posedge clock);
            evt(k);
            rdReg(ADDR_ELAPSED);
            chk(32'(rd < 3), 32'h1);
        end
        // Power save mid-count: entry restarts, time-out wakes
        powerSaveIdle <= lfsr[0];
        repeat (100) @(posedge clock);
        evt(2);
        chk(32'(powerSaved), 32'h1);
        waitEv(1'b1);
        chk(32'((cyc + 9) / (DIV * expTicks(8'h41))), 32'h1);
        rdReg(ADDR_RESET_CTRL);
        chk(rd, lfsr[0] ? 32'h34 : 32'h38);
        // Mid-run reset drops the software enable again
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rdReg(ADDR_RESET_CTRL);
        chk(rd, 32'h0);
        // Early clear with the window on
        wrReg(ADDR_RESET_CTRL, 32'h20);
        wrReg(ADDR_CONFIG, 32'h01);
        evt(0);
        waitEv(1'b0);
        chk(32'(cyc < 4), 32'h1);
        // Always-on setting overrides the soft enable
        wrReg(ADDR_CONFIG, 32'hc0);
        wrReg(ADDR_RESET_CTRL, 32'h0);
        repeat (4) @(negedge clock);
        chk(32'(lpRcEnable), 32'h1);
        summarize();
    end
endmodule
